// ### rtl/datp_pkg.sv
// Shared constants and types for the translate-address result page builder
package datp_pkg;

	// Result page header
	localparam logic [7:0] PAGE_CODE = 8'h40;
	localparam logic [7:0] RSVD_BYTE = 8'h00;
	localparam logic [15:0] LEN_DESC_BYTES = 16'h0002; // Two descriptor bytes
	localparam int ENTRY_BYTES = 8;
	localparam int ENTRY_SHIFT = 3; // log2 of ENTRY_BYTES
	localparam logic [2:0] HDR_LAST_IDX = 3'h5;
	localparam logic [2:0] ENT_LAST_IDX = 3'h7;

	// Field positions of descriptor byte 5
	localparam int RESERVED_REGION_FLAG_BIT = 7;
	localparam int SPSEC_BIT = 6;
	localparam int SPTRK_BIT = 5;

	// Sense reported for an unsupported format
	localparam logic [3:0] SENSE_ILLEGAL_REQ = 4'h5;
	localparam logic [7:0] ASC_INVALID_PARAM = 8'h26;
	localparam logic [3:0] SENSE_NONE = 4'h0;
	localparam logic [7:0] ASC_NONE = 8'h00;

	// Log page selector codes
	localparam logic [7:0] LOG_CODE_SUPPORTED = 8'h00;
	localparam logic [7:0] LOG_CODE_BUF_OVR = 8'h01;
	localparam logic [7:0] LOG_CODE_WRITE_ERR = 8'h02;
	localparam logic [7:0] LOG_CODE_READ_ERR = 8'h03;
	localparam logic [7:0] LOG_CODE_VERIFY_ERR = 8'h05;
	localparam logic [7:0] LOG_CODE_NONMEDIUM = 8'h06;
	localparam logic [7:0] LOG_CODE_RECENT = 8'h07;

	// Medium-type codes
	localparam logic [7:0] MED_CODE_DEFAULT = 8'h00;
	localparam logic [7:0] MED_CODE_FLEX_SS = 8'h01;
	localparam logic [7:0] MED_CODE_FLEX_DS = 8'h02;

	typedef enum logic [2:0] {
		DATP_LOG_SUPPORTED,
		DATP_LOG_BUF_OVR,
		DATP_LOG_WRITE_ERR,
		DATP_LOG_READ_ERR,
		DATP_LOG_VERIFY_ERR,
		DATP_LOG_NONMEDIUM,
		DATP_LOG_RECENT,
		DATP_LOG_OTHER
	} datp_log_t;

	typedef enum logic [1:0] {
		DATP_MED_DEFAULT,
		DATP_MED_FLEX_SS,
		DATP_MED_FLEX_DS,
		DATP_MED_OTHER
	} datp_med_t;

endpackage : datp_pkg

// ### rtl/datp_decode.sv
// Log page selector and medium-type code decoder
`timescale 1ns/1ns
module datp_decode (
	// Codes to decode
	input wire logic [7:0] log_code_i,
	input wire logic [7:0] med_code_i,
	// Decoded kinds
	output datp_pkg::datp_log_t log_kind_o,
	output logic log_known_o,
	output datp_pkg::datp_med_t med_kind_o,
	output logic med_known_o
);
	import datp_pkg::*;

	// Log page selector decode
	always_comb begin
		log_known_o = 1'b1;
		case (log_code_i)
			LOG_CODE_SUPPORTED: log_kind_o = DATP_LOG_SUPPORTED;
			LOG_CODE_BUF_OVR: log_kind_o = DATP_LOG_BUF_OVR;
			LOG_CODE_WRITE_ERR: log_kind_o = DATP_LOG_WRITE_ERR;
			LOG_CODE_READ_ERR: log_kind_o = DATP_LOG_READ_ERR;
			LOG_CODE_VERIFY_ERR: log_kind_o = DATP_LOG_VERIFY_ERR;
			LOG_CODE_NONMEDIUM: log_kind_o = DATP_LOG_NONMEDIUM;
			LOG_CODE_RECENT: log_kind_o = DATP_LOG_RECENT;
			default: begin
				log_kind_o = DATP_LOG_OTHER;
				log_known_o = 1'b0;
			end
		endcase
	end

	// Medium-type decode
	always_comb begin
		med_known_o = 1'b1;
		case (med_code_i)
			MED_CODE_DEFAULT: med_kind_o = DATP_MED_DEFAULT;
			MED_CODE_FLEX_SS: med_kind_o = DATP_MED_FLEX_SS;
			MED_CODE_FLEX_DS: med_kind_o = DATP_MED_FLEX_DS;
			default: begin
				med_kind_o = DATP_MED_OTHER;
				med_known_o = 1'b0;
			end
		endcase
	end

endmodule : datp_decode

// ### rtl/datp_top.sv
// Translate-address result page builder with format check and code decode
`timescale 1ns/1ns
// Contract
// - Page is 4-byte header, two descriptor bytes, then zero or more entries.
// - Page length counts the bytes following the length field.
// - Supplied format echoes the accepted send request unchanged.
// - Reserved-region flag set when any part of address is reserved.
// - Entries may be omitted when the whole address is reserved.
// - Spare-sector flag only when known in spare sector, else zero.
// - Spare-track flag set when on spare track or unknown.
// - Translated format echoes the accepted send request target format.
// - Logical block entries carry block number in bytes 0-3, rest zero.
// - Every covered address is emitted as one entry, two in bytes-from-index, unless the whole address is reserved and omitted.
// - Bytes-from-index emits start then end value per covered address.
// - Log codes: read errors 03h, verify errors 05h, write errors 02h.
// - Log codes: recent events 07h, non-medium 06h, supported list 00h.
// - Medium codes: 00h default, 01h single-sided, 02h double-sided flexible.
// - Unsupported format ends send request with check, illegal request, bad field.
module datp_top #(
	parameter int CNT_W = 8,
	parameter logic [2:0] FMT_LBA = 3'h0,
	parameter logic [2:0] FMT_BFI = 3'h4,
	parameter logic [2:0] FMT_PSEC = 3'h5
) (
	// Clock, reset, enable
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	// Send request
	input wire logic SEND_VALID_I,
	input wire logic [2:0] SRC_FMT_I,
	input wire logic [2:0] TGT_FMT_I,
	input wire logic [7:0] FMT_SUPPORT_I,
	output logic SEND_DONE_O,
	output logic SEND_CHECK_O,
	output logic [3:0] SENSE_KEY_O,
	output logic [7:0] SENSE_ASC_O,
	// Translation outcome
	input wire logic RECV_START_I,
	input wire logic [CNT_W-1:0] ADDR_COUNT_I,
	input wire logic PART_RESERVED_I,
	input wire logic ALL_RESERVED_I,
	input wire logic OMIT_RESERVED_I,
	input wire logic SPARE_SECTOR_I,
	input wire logic SPARE_SECTOR_KNOWN_I,
	input wire logic SPARE_TRACK_I,
	input wire logic SPARE_TRACK_KNOWN_I,
	output logic BUSY_O,
	// Translated entries in
	input wire logic ENTRY_VALID_I,
	input wire logic [63:0] ENTRY_ADDR_I,
	output logic ENTRY_READY_O,
	// Page byte stream out
	input wire logic PAGE_READY_I,
	output logic [7:0] PAGE_BYTE_O,
	output logic PAGE_VALID_O,
	output logic PAGE_LAST_O,
	// Code decode
	input wire logic [7:0] LOG_CODE_I,
	input wire logic [7:0] MED_CODE_I,
	output datp_pkg::datp_log_t LOG_KIND_O,
	output logic LOG_KNOWN_O,
	output datp_pkg::datp_med_t MED_KIND_O,
	output logic MED_KNOWN_O
);
	import datp_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HDR,
		ST_EWAIT,
		ST_EBYTE
	} datp_st_t;

	typedef struct packed {
		datp_st_t st;
		logic [2:0] idx;
		logic [CNT_W:0] left;
		logic [2:0] src_fmt;
		logic [2:0] tgt_fmt;
		logic reserved_region_flag;
		logic spsec;
		logic sptrk;
		logic [15:0] len;
		logic [63:0] ent;
		logic entry_rdy;
		logic [7:0] pbyte;
		logic pvld;
		logic plast;
		logic send_done;
		logic send_chk;
		logic [3:0] skey;
		logic [7:0] asc;
		datp_log_t log_kind;
		logic log_known;
		datp_med_t med_kind;
		logic med_known;
		logic busy;
	} datp_state_t;

	// Reset image of the whole state, every field spelled out
	localparam datp_state_t RST_STATE = '{
		st: ST_IDLE,
		idx: 3'h0,
		left: '0,
		src_fmt: 3'h0,
		tgt_fmt: 3'h0,
		reserved_region_flag: 1'b0,
		spsec: 1'b0,
		sptrk: 1'b0,
		len: 16'h0000,
		ent: 64'h0000_0000_0000_0000,
		entry_rdy: 1'b0,
		pbyte: 8'h00,
		pvld: 1'b0,
		plast: 1'b0,
		send_done: 1'b0,
		send_chk: 1'b0,
		skey: SENSE_NONE,
		asc: ASC_NONE,
		log_kind: DATP_LOG_SUPPORTED,
		log_known: 1'b0,
		med_kind: DATP_MED_DEFAULT,
		med_known: 1'b0,
		busy: 1'b0
	};

	datp_state_t r;
	datp_state_t n;
	datp_log_t dec_log;
	datp_med_t dec_med;
	logic dec_log_known;
	logic dec_med_known;
	logic slot;
	logic [CNT_W:0] ent_total;
	logic [7:0] hdr_byte;
	logic [7:0] desc_byte;

	// Code decoders
	datp_decode u_decode (
		.log_code_i(LOG_CODE_I),
		.med_code_i(MED_CODE_I),
		.log_kind_o(dec_log),
		.log_known_o(dec_log_known),
		.med_kind_o(dec_med),
		.med_known_o(dec_med_known)
	);

	// Entry count for the request being built
	always_comb begin
		if (ALL_RESERVED_I && OMIT_RESERVED_I) begin
			ent_total = '0;
		end else if (r.tgt_fmt == FMT_BFI) begin
			ent_total = {ADDR_COUNT_I, 1'b0};
		end else begin
			ent_total = {1'b0, ADDR_COUNT_I};
		end
	end

	// Descriptor byte: flags in their fields, translated format at the bottom
	always_comb begin
		desc_byte = {5'h00, r.tgt_fmt};
		desc_byte[RESERVED_REGION_FLAG_BIT] = r.reserved_region_flag;
		desc_byte[SPSEC_BIT] = r.spsec;
		desc_byte[SPTRK_BIT] = r.sptrk;
	end

	// Header and descriptor byte select
	always_comb begin
		case (r.idx)
			3'h0: hdr_byte = PAGE_CODE;
			3'h1: hdr_byte = RSVD_BYTE;
			3'h2: hdr_byte = r.len[15:8];
			3'h3: hdr_byte = r.len[7:0];
			3'h4: hdr_byte = {5'h00, r.src_fmt};
			default: hdr_byte = desc_byte;
		endcase
	end

	// Output slot free when empty or being taken
	assign slot = !r.pvld || PAGE_READY_I;

	// Next-state logic
	always_comb begin
		n = r;
		n.send_done = 1'b0;
		n.log_kind = dec_log;
		n.log_known = dec_log_known;
		n.med_kind = dec_med;
		n.med_known = dec_med_known;
		// Format check on send request
		if (SEND_VALID_I) begin
			n.send_done = 1'b1;
			if (FMT_SUPPORT_I[SRC_FMT_I] && FMT_SUPPORT_I[TGT_FMT_I]) begin
				n.src_fmt = SRC_FMT_I;
				n.tgt_fmt = TGT_FMT_I;
				n.send_chk = 1'b0;
				n.skey = SENSE_NONE;
				n.asc = ASC_NONE;
			end else begin
				n.send_chk = 1'b1;
				n.skey = SENSE_ILLEGAL_REQ;
				n.asc = ASC_INVALID_PARAM;
			end
		end
		// Retire byte taken by the sink
		if (r.pvld && PAGE_READY_I) begin
			n.pvld = 1'b0;
			n.plast = 1'b0;
		end
		case (r.st)
			// Wait for a page request, latch count and flags
			ST_IDLE: begin
				if (RECV_START_I) begin
					n.st = ST_HDR;
					n.idx = 3'h0;
					n.left = ent_total;
					n.len = LEN_DESC_BYTES + 16'(ent_total) * 16'(ENTRY_BYTES);
					n.reserved_region_flag = PART_RESERVED_I || ALL_RESERVED_I;
					n.spsec = SPARE_SECTOR_KNOWN_I && SPARE_SECTOR_I;
					n.sptrk = SPARE_TRACK_I || !SPARE_TRACK_KNOWN_I;
				end
			end

			// Header and descriptor bytes, one per free slot
			ST_HDR: begin
				if (slot) begin
					n.pbyte = hdr_byte;
					n.pvld = 1'b1;
					if (r.idx == HDR_LAST_IDX) begin
						if (r.left == '0) begin
							n.plast = 1'b1;
							n.st = ST_IDLE;
						end else begin
							n.st = ST_EWAIT;
							n.entry_rdy = 1'b1;
						end
					end else begin
						n.idx = r.idx + 3'h1;
					end
				end
			end

			// Take the next translated entry from the source
			ST_EWAIT: begin
				if (ENTRY_VALID_I && r.entry_rdy) begin
					n.entry_rdy = 1'b0;
					n.idx = 3'h0;
					n.left = r.left - 1'b1;
					n.st = ST_EBYTE;
					if (r.tgt_fmt == FMT_LBA) begin
						n.ent = {ENTRY_ADDR_I[63:32], 32'h0000_0000};
					end else begin
						n.ent = ENTRY_ADDR_I;
					end
				end
			end

			// Shift the entry out, most significant byte first
			ST_EBYTE: begin
				if (slot) begin
					n.pbyte = r.ent[63:56];
					n.ent = {r.ent[55:0], 8'h00};
					n.pvld = 1'b1;
					if (r.idx == ENT_LAST_IDX) begin
						if (r.left == '0) begin
							n.plast = 1'b1;
							n.st = ST_IDLE;
						end else begin
							n.st = ST_EWAIT;
							n.entry_rdy = 1'b1;
						end
					end else begin
						n.idx = r.idx + 3'h1;
					end
				end
			end

			// Stray code falls back to idle
			default: begin
				n.st = ST_IDLE;
			end
		endcase
		// Busy flag kept in a flip-flop so the output is registered
		n.busy = (n.st != ST_IDLE);
	end

	// State register, frozen while enable is low
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			r <= RST_STATE;
		end else if (CE_I) begin
			r <= n;
		end
	end

	// Outputs straight from state
	assign SEND_DONE_O = r.send_done;
	assign SEND_CHECK_O = r.send_chk;
	assign SENSE_KEY_O = r.skey;
	assign SENSE_ASC_O = r.asc;
	assign BUSY_O = r.busy;
	assign ENTRY_READY_O = r.entry_rdy;
	assign PAGE_BYTE_O = r.pbyte;
	assign PAGE_VALID_O = r.pvld;
	assign PAGE_LAST_O = r.plast;
	assign LOG_KIND_O = r.log_kind;
	assign LOG_KNOWN_O = r.log_known;
	assign MED_KIND_O = r.med_kind;
	assign MED_KNOWN_O = r.med_known;

endmodule : datp_top

// ### testbench/datp_top_monitor.sv
// Checker for the page builder ports
`timescale 1ns/1ns
module datp_top_monitor
	import datp_pkg::*;
(
	// Watched ports
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic SEND_VALID_I,
	input wire logic [2:0] SRC_FMT_I,
	input wire logic [2:0] TGT_FMT_I,
	input wire logic [7:0] FMT_SUPPORT_I,
	input wire logic SEND_DONE_O,
	input wire logic SEND_CHECK_O,
	input wire logic [3:0] SENSE_KEY_O,
	input wire logic [7:0] SENSE_ASC_O,
	input wire logic RECV_START_I,
	input wire logic BUSY_O,
	input wire logic PAGE_READY_I,
	input wire logic [7:0] PAGE_BYTE_O,
	input wire logic PAGE_VALID_O,
	input wire logic [7:0] LOG_CODE_I,
	input wire logic [7:0] MED_CODE_I,
	input wire datp_log_t LOG_KIND_O,
	input wire datp_med_t MED_KIND_O
);
	logic ok;
	// Both requested formats supported
	assign ok = FMT_SUPPORT_I[SRC_FMT_I] && FMT_SUPPORT_I[TGT_FMT_I];
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	// Send answer and sense
	AST_DONE: assert property (CE_I && SEND_VALID_I |=> SEND_DONE_O) else $error("no done");
	AST_BAD: assert property (CE_I && SEND_VALID_I && !ok |=> SEND_CHECK_O
		&& SENSE_KEY_O == 4'h5 && SENSE_ASC_O == 8'h26) else $error("bad sense");
	AST_GOOD: assert property (CE_I && SEND_VALID_I && ok |=> !SEND_CHECK_O
		&& SENSE_KEY_O == 4'h0) else $error("false check");
	// Page start and stall hold
	AST_START: assert property (CE_I && RECV_START_I && !BUSY_O && !PAGE_VALID_O ##1 CE_I
		|-> BUSY_O ##1 (PAGE_VALID_O && PAGE_BYTE_O == 8'h40)) else $error("bad start");
	AST_HOLD: assert property (PAGE_VALID_O && !PAGE_READY_I |=> PAGE_VALID_O
		&& $stable(PAGE_BYTE_O)) else $error("byte dropped");
	// Code decode
	AST_LOG_RD: assert property (CE_I && LOG_CODE_I == 8'h03 |=> LOG_KIND_O == DATP_LOG_READ_ERR)
		else $error("log read");
	AST_LOG_SUP: assert property (CE_I && LOG_CODE_I == 8'h00 |=> LOG_KIND_O == DATP_LOG_SUPPORTED)
		else $error("log list");
	AST_MED_DS: assert property (CE_I && MED_CODE_I == 8'h02 |=> MED_KIND_O == DATP_MED_FLEX_DS)
		else $error("medium");
	// Main scenarios
	cover property (SEND_DONE_O && SEND_CHECK_O);
	cover property (PAGE_VALID_O && !PAGE_READY_I);
	cover property (RECV_START_I && !BUSY_O);
endmodule : datp_top_monitor

bind datp_top datp_top_monitor mon (.*);

// ### testbench/datp_host_model.sv
// Host side sink of result page bytes
`timescale 1ns/1ns
module datp_host_model (
	// Clock and stall
	input wire logic clk_i,
	input wire logic stall_i,
	// Page stream
	input wire logic vld_i,
	input wire logic [7:0] byte_i,
	input wire logic last_i,
	output logic rdy_o = 1'b1
);
	logic [7:0] q [$];
	int last_at = -1;
	int last_n = 0;
	// Ready dropped at random while stalling
	always @(negedge clk_i) rdy_o <= !(stall_i && 1'($urandom));
	// Keep every byte taken
	always @(posedge clk_i) begin
		if (vld_i && rdy_o) begin
			if (last_i) begin
				last_at = q.size();
				last_n++;
			end
			q.push_back(byte_i);
		end
	end
endmodule : datp_host_model

// ### testbench/datp_top_tb.sv
// Self-checking bench for the page builder
`timescale 1ns/1ns
module datp_top_tb;
	import datp_pkg::*;
	logic CLK_I = 0, RST_N_I = 0, CE_I = 1, SEND_VALID_I = 0, RECV_START_I = 0, stall = 0;
	logic PART_RESERVED_I, ALL_RESERVED_I, OMIT_RESERVED_I, SPARE_SECTOR_I;
	logic SPARE_SECTOR_KNOWN_I, SPARE_TRACK_I, SPARE_TRACK_KNOWN_I, ENTRY_VALID_I;
	logic PAGE_READY_I, SEND_DONE_O, SEND_CHECK_O, BUSY_O, ENTRY_READY_O;
	logic PAGE_VALID_O, PAGE_LAST_O, LOG_KNOWN_O, MED_KNOWN_O;
	logic [2:0] SRC_FMT_I = 0, TGT_FMT_I = 0, cs, ct;
	logic [7:0] FMT_SUPPORT_I = 8'h31, ADDR_COUNT_I = 0, LOG_CODE_I = 0, MED_CODE_I = 0;
	logic [7:0] PAGE_BYTE_O, SENSE_ASC_O;
	logic [6:0] fl = 0;
	logic [3:0] SENSE_KEY_O;
	logic [63:0] ENTRY_ADDR_I, ents [8];
	datp_log_t LOG_KIND_O;
	datp_med_t MED_KIND_O;
	datp_log_t ltab [8] = '{DATP_LOG_SUPPORTED, DATP_LOG_BUF_OVR, DATP_LOG_WRITE_ERR,
		DATP_LOG_READ_ERR, DATP_LOG_OTHER, DATP_LOG_VERIFY_ERR, DATP_LOG_NONMEDIUM,
		DATP_LOG_RECENT};
	int ei = 0, ne = 0, i, err_total = 0, n_checks = 0, cyc = 0;
	datp_top dut (.*);
	datp_host_model h (.clk_i(CLK_I), .stall_i(stall), .vld_i(PAGE_VALID_O),
		.byte_i(PAGE_BYTE_O), .last_i(PAGE_LAST_O), .rdy_o(PAGE_READY_I));
	// Flags and entry source
	assign {SPARE_TRACK_KNOWN_I, SPARE_TRACK_I, SPARE_SECTOR_KNOWN_I, SPARE_SECTOR_I,
		OMIT_RESERVED_I, ALL_RESERVED_I, PART_RESERVED_I} = fl;
	assign ENTRY_VALID_I = ei < ne;
	assign ENTRY_ADDR_I = ents[ei[2:0]];
	// Next entry once taken
	always @(posedge CLK_I) if (ENTRY_VALID_I && ENTRY_READY_O) ei <= ei + 1;
	// Clock
	initial forever #25 CLK_I = ~CLK_I;
	// Hang guard
	always @(posedge CLK_I) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end
	task chk(input logic [63:0] g, input logic [63:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task send(input logic [2:0] s, input logic [2:0] t);
		logic ok;
		ok = FMT_SUPPORT_I[s] && FMT_SUPPORT_I[t];
		@(negedge CLK_I);
		SRC_FMT_I = s;
		TGT_FMT_I = t;
		SEND_VALID_I = 1;
		@(negedge CLK_I);
		SEND_VALID_I = 0;
		chk(64'(SEND_DONE_O), 64'h1);
		chk(64'({SEND_CHECK_O, SENSE_KEY_O, SENSE_ASC_O}), ok ? 64'h0 : 64'h1526);
		if (ok) begin
			cs = s;
			ct = t;
		end
	endtask : send
	task page(input logic [7:0] n, input logic [6:0] f);
		logic [7:0] e [$];
		logic [15:0] len;
		int k, m;
		m = f[1] && f[2] ? 0 : (ct == 3'h4 ? 2 * n : n);
		len = 16'(2 + 8 * m);
		e = '{8'h40, 8'h00, len[15:8], len[7:0], {5'h0, cs},
			{f[0] | f[1], f[3] & f[4], f[5] | !f[6], 2'h0, ct}};
		for (k = 0; k < 8; k++) ents[k] = {$urandom, $urandom};
		for (k = 0; k < 8 * m; k++)
			e.push_back(ct == 3'h0 && k % 8 > 3 ? 8'h00 : ents[k / 8][63 - 8 * (k % 8) -: 8]);
		h.q.delete();
		h.last_n = 0;
		h.last_at = -1;
		ei = 0;
		ne = m;
		@(negedge CLK_I);
		ADDR_COUNT_I = n;
		fl = f;
		RECV_START_I = 1;
		@(negedge CLK_I);
		RECV_START_I = 0;
		for (k = 0; (BUSY_O || PAGE_VALID_O) && k < 500; k++) @(negedge CLK_I);
		chk(64'(h.q.size()), 64'(e.size()));
		foreach (e[j]) if (j < h.q.size()) chk(64'(h.q[j]), 64'(e[j]));
		chk({32'(h.last_n), 32'(h.last_at)}, {32'd1, 32'(e.size() - 1)});
	endtask : page
	task final_report;
		$display("TB: checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	// Main sequence
	initial begin
		void'($urandom(75));
		repeat (12) @(negedge CLK_I);
		RST_N_I = 1;
		send(3'h0, 3'h4);
		page(8'h3, 7'h40);
		// Enable low: a refused request must not raise done, check or sense key
		@(negedge CLK_I);
		CE_I = 0;
		SRC_FMT_I = 3'h1;
		SEND_VALID_I = 1;
		@(negedge CLK_I);
		SEND_VALID_I = 0;
		CE_I = 1;
		chk(64'({SEND_DONE_O, SEND_CHECK_O, SENSE_KEY_O}), 64'h0);
		$display("TB: enable test done");
		send(3'h5, 3'h1);
		page(8'h1, 7'h06);
		$display("TB: directed tests done");
		for (i = 0; i < 16; i++) begin
			stall = 1'($urandom);
			FMT_SUPPORT_I = 8'($urandom) | 8'h31;
			send(3'($urandom), 3'($urandom));
			page(8'($urandom_range(3, 0)), 7'($urandom));
			$display("TB: test %0d done", i);
		end
		for (i = 0; i < 9; i++) begin
			@(negedge CLK_I);
			LOG_CODE_I = i[7:0];
			MED_CODE_I = i[7:0];
			@(negedge CLK_I);
			chk({LOG_KNOWN_O, LOG_KIND_O}, {i != 4 && i < 8, i < 8 ? ltab[i] : DATP_LOG_OTHER});
			chk({MED_KNOWN_O, MED_KIND_O}, {i < 3, i < 3 ? i[1:0] : 2'h3});
		end
		$display("TB: decode test done");
		final_report();
	end
endmodule : datp_top_tb
